// ===== lut_pkg.sv
package lut_pkg;

  // ==========================================================
  // Data path sizes
  localparam int PIX_W      = 12;
  localparam int LUT_DEPTH  = 4096;
  localparam int FIFO_DEPTH = 4;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_FACTOR  = 8'h04;
  localparam logic [7:0] OFF_CHOICE  = 8'h08;
  localparam logic [7:0] OFF_WIDTH   = 8'h0c;
  localparam logic [7:0] OFF_POS     = 8'h10;
  localparam logic [7:0] OFF_CONTENT = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;

  // ==========================================================
  // Field positions and codes
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_KIND_BIT = 1;
  localparam int STAT_FIFO_BIT = 0;
  localparam int STAT_OUT_BIT  = 1;
  localparam int STAT_RDY_BIT  = 2;

  localparam logic       KIND_PROG  = 1'b0;
  localparam logic       KIND_POWER = 1'b1;
  localparam logic [3:0] CHOICE_BRIGHT_ONE = 4'h0;
  localparam logic [3:0] WIDTH_TWELVE      = 4'h0;

  // ==========================================================
  // Reset values
  localparam logic        EN_RST     = 1'b0;
  localparam logic        KIND_RST   = KIND_PROG;
  localparam logic [11:0] FACTOR_RST = 12'h100;
  localparam logic [11:0] POS_RST    = 12'h000;

  // ==========================================================
  // Bus answers and power-law constants
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [12:0] POWER_FULL  = 13'h1000;
  localparam logic [7:0]  POWER_MAX_SHIFT = 8'h0c;

endpackage : lut_pkg

// ===== pixel_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module pixel_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  // Filling side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output var  logic             in_ready_out,
  // Draining side
  output logic      [WIDTH-1:0] out_data_out,
  output var  logic             out_valid_out,
  input  wire logic             out_ready_in
);

  // Depth must be a power of two so the pointers wrap freely
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    cnt_d;
  logic             push;
  logic             pop;

  assign push         = in_valid_in & in_ready_out;
  assign pop          = out_valid_out & out_ready_in;
  assign out_data_out = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // Flags registered from the next count keeps both ports glitch free
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cnt_q         <= '0;
      in_ready_out  <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      cnt_q         <= cnt_d;
      in_ready_out  <= (cnt_d != CW'(DEPTH));
      out_valid_out <= (cnt_d != '0);
    end
  end

endmodule : pixel_fifo

`default_nettype wire

// ===== pixel_lookup_table.sv
// What this block does
// - Map pixels only while table is enabled
// - Report programmable or power-law table kind
// - Power-law raises pixel to factor exponent
// - Selector targets only brightness table one
// - Entry width reports twelve-bit entries
// - Position register indexes the accessed entry
// - Content read returns entry at position
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pixel_lookup_table
  import lut_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rstn_in,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] awaddr_in,
  input  wire logic              awvalid_in,
  output var  logic              awready_out,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic [3:0]        wstrb_in,
  input  wire logic              wvalid_in,
  output var  logic              wready_out,
  // AXI4-Lite write response
  output var  logic [1:0]        bresp_out,
  output var  logic              bvalid_out,
  input  wire logic              bready_in,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr_in,
  input  wire logic              arvalid_in,
  output var  logic              arready_out,
  output var  logic [DATA_W-1:0] rdata_out,
  output var  logic [1:0]        rresp_out,
  output var  logic              rvalid_out,
  input  wire logic              rready_in,
  // Pixel stream in
  input  wire logic [PIX_W-1:0]  pix_data_in,
  input  wire logic              pix_valid_in,
  output      logic              pix_ready_out,
  // Pixel stream out
  output var  logic [PIX_W-1:0]  pix_data_out,
  output var  logic              pix_valid_out,
  input  wire logic              pix_ready_in
);

  // ==========================================================
  // Settings and table storage
  logic              table_enable_state_q;
  logic              table_kind_q;
  logic [11:0]       power_exponent_factor_q;
  logic [3:0]        table_choice_q;
  logic [11:0]       table_entry_position_q;
  logic [PIX_W-1:0]  lut_mem [LUT_DEPTH];

  // ==========================================================
  // Bus side state
  logic              aw_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_full_q;
  logic [DATA_W-1:0] w_data_q;
  logic [3:0]        w_strb_q;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              do_write;
  logic [DATA_W-1:0] wr_merged;
  logic [PIX_W-1:0]  content_rd;

  // ==========================================================
  // Stream side signals
  logic [PIX_W-1:0]  fifo_data;
  logic              fifo_vld;
  logic              fifo_take;
  logic              pop;
  logic [PIX_W-1:0]  lut_rd;
  logic [PIX_W-1:0]  power_rd;
  logic [PIX_W-1:0]  mapped;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] apply_strb(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_CTRL, OFF_FACTOR, OFF_CHOICE, OFF_WIDTH,
      OFF_POS, OFF_CONTENT, OFF_STATUS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction : addr_hit

  function automatic logic [31:0] reg_view(input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      OFF_CTRL: begin
        v[CTRL_EN_BIT]   = table_enable_state_q;
        v[CTRL_KIND_BIT] = table_kind_q;
      end
      OFF_FACTOR:  v[11:0] = power_exponent_factor_q;
      OFF_CHOICE:  v[3:0]  = table_choice_q;
      OFF_WIDTH:   v[3:0]  = WIDTH_TWELVE;
      OFF_POS:     v[11:0] = table_entry_position_q;
      OFF_CONTENT: v[11:0] = content_rd;
      OFF_STATUS: begin
        v[STAT_FIFO_BIT] = fifo_vld;
        v[STAT_OUT_BIT]  = pix_valid_out;
        v[STAT_RDY_BIT]  = pix_ready_out;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_view

  // Log/antilog approximation: linear mantissa both ways, so the
  // curve is monotonic but only a few percent accurate mid-range
  function automatic logic [11:0] power_map(
    input logic [11:0] x,
    input logic [11:0] g
  );
    logic [3:0]  p;
    logic [11:0] sh;
    logic [11:0] l;
    logic [23:0] m;
    logic [12:0] y;
    p = 4'h0;
    for (int i = 0; i < 12; i++) begin
      if (x[i]) begin
        p = 4'(i);
      end
    end
    sh = x << (4'd11 - p);
    l  = {4'd12 - p, 8'h00} - {4'h0, sh[10:3]};
    m  = l * g;
    y  = POWER_FULL - {2'b00, m[15:8], 3'b000};
    if (m[23:16] > POWER_MAX_SHIFT) begin
      y = 13'h0000;
    end else begin
      y = y >> m[19:16];
    end
    if (x == 12'h000) begin
      power_map = 12'h000;
    end else if (y[12]) begin
      power_map = 12'hfff;
    end else begin
      power_map = y[11:0];
    end
  endfunction : power_map

  // ==========================================================
  // Write channel
  assign aw_hs     = awvalid_in & awready_out;
  assign w_hs      = wvalid_in & wready_out;
  assign do_write  = aw_full_q & w_full_q & ~bvalid_out;

  // Process form so the merge follows the register it reads back
  always_comb begin
    wr_merged = apply_strb(reg_view(aw_addr_q), w_data_q, w_strb_q);
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      aw_full_q   <= 1'b0;
      aw_addr_q   <= '0;
      awready_out <= 1'b0;
    end else if (aw_hs) begin
      aw_full_q   <= 1'b1;
      aw_addr_q   <= awaddr_in;
      awready_out <= 1'b0;
    end else begin
      if (do_write) begin
        aw_full_q <= 1'b0;
      end
      if (!aw_full_q && !bvalid_out) begin
        awready_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      w_full_q   <= 1'b0;
      w_data_q   <= '0;
      w_strb_q   <= '0;
      wready_out <= 1'b0;
    end else if (w_hs) begin
      w_full_q   <= 1'b1;
      w_data_q   <= wdata_in;
      w_strb_q   <= wstrb_in;
      wready_out <= 1'b0;
    end else begin
      if (do_write) begin
        w_full_q <= 1'b0;
      end
      if (!w_full_q && !bvalid_out) begin
        wready_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      bvalid_out <= 1'b0;
      bresp_out  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_out <= 1'b1;
      bresp_out  <= addr_hit(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready_in) begin
      bvalid_out <= 1'b0;
    end
  end

  // ==========================================================
  // Read channel
  assign ar_hs = arvalid_in & arready_out;

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      arready_out <= 1'b0;
      rvalid_out  <= 1'b0;
      rdata_out   <= '0;
      rresp_out   <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_out <= 1'b0;
      rvalid_out  <= 1'b1;
      rdata_out   <= reg_view(araddr_in);
      rresp_out   <= addr_hit(araddr_in) ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (rready_in) begin
        rvalid_out <= 1'b0;
      end
      if (!rvalid_out) begin
        arready_out <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Settings
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      table_enable_state_q <= EN_RST;
      table_kind_q         <= KIND_RST;
    end else if (do_write && aw_addr_q == OFF_CTRL) begin
      table_enable_state_q <= wr_merged[CTRL_EN_BIT];
      table_kind_q         <= wr_merged[CTRL_KIND_BIT];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      power_exponent_factor_q <= FACTOR_RST;
    end else if (do_write && aw_addr_q == OFF_FACTOR) begin
      power_exponent_factor_q <= wr_merged[11:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      table_choice_q <= CHOICE_BRIGHT_ONE;
    end else if (do_write && aw_addr_q == OFF_CHOICE &&
                 wr_merged[3:0] == CHOICE_BRIGHT_ONE) begin
      table_choice_q <= wr_merged[3:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      table_entry_position_q <= POS_RST;
    end else if (do_write && aw_addr_q == OFF_POS) begin
      table_entry_position_q <= wr_merged[11:0];
    end
  end

  // ==========================================================
  // Table storage, left unreset so it maps to block memory
  // entry at position
  assign content_rd = lut_mem[table_entry_position_q];

  always_ff @(posedge mclk_in) begin
    if (do_write && aw_addr_q == OFF_CONTENT) begin
      lut_mem[table_entry_position_q] <= wr_merged[11:0];
    end
  end

  // ==========================================================
  // Pixel path
  pixel_fifo #(
    .WIDTH (PIX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (mclk_in),
    .rstn_in       (rstn_in),
    .in_data_in    (pix_data_in),
    .in_valid_in   (pix_valid_in),
    .in_ready_out  (pix_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_vld),
    .out_ready_in  (fifo_take)
  );

  assign fifo_take = ~pix_valid_out | pix_ready_in;
  assign pop       = fifo_vld & fifo_take;
  assign lut_rd    = lut_mem[fifo_data];
  assign power_rd  = power_map(fifo_data, power_exponent_factor_q);

  always_comb begin
    if (!table_enable_state_q) begin
      mapped = fifo_data;
    end else if (table_kind_q == KIND_POWER) begin
      mapped = power_rd;
    end else begin
      mapped = lut_rd;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pix_valid_out <= 1'b0;
    end else if (fifo_take) begin
      pix_valid_out <= fifo_vld;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pix_data_out <= '0;
    end else if (pop) begin
      pix_data_out <= mapped;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  chk_bypass_raw: assert property (
    pop && !table_enable_state_q |=> pix_data_out == $past(fifo_data))
    else $error("disabled table altered a pixel");

  chk_table_apply: assert property (
    pop && table_enable_state_q && table_kind_q == KIND_PROG
    |=> pix_data_out == $past(lut_rd))
    else $error("programmable table not applied");

  chk_power_flat: assert property (
    pop && table_enable_state_q && table_kind_q == KIND_POWER &&
    power_exponent_factor_q == 12'h000 && fifo_data != 12'h000
    |=> pix_data_out == 12'hfff)
    else $error("zero exponent did not give full scale");

  chk_power_zero: assert property (
    pop && table_enable_state_q && table_kind_q == KIND_POWER &&
    fifo_data == 12'h000 |=> pix_data_out == 12'h000)
    else $error("power curve moved black level");

  chk_kind_report: assert property (
    ar_hs && araddr_in == OFF_CTRL
    |=> rvalid_out && rdata_out[CTRL_KIND_BIT] == $past(table_kind_q))
    else $error("table kind misreported");

  chk_choice_fixed: assert property (
    table_choice_q == CHOICE_BRIGHT_ONE)
    else $error("selector left the only table");

  chk_width_report: assert property (
    ar_hs && araddr_in == OFF_WIDTH
    |=> rvalid_out && rdata_out[3:0] == WIDTH_TWELVE)
    else $error("entry width misreported");

  chk_pos_store: assert property (
    do_write && aw_addr_q == OFF_POS && w_strb_q[1:0] == 2'b11
    |=> table_entry_position_q == $past(w_data_q[11:0]))
    else $error("position write lost");

  chk_content_read: assert property (
    ar_hs && araddr_in == OFF_CONTENT
    |=> rdata_out[11:0] == $past(content_rd) && rdata_out[31:12] == '0)
    else $error("content read wrong entry");

  chk_content_write: assert property (
    do_write && aw_addr_q == OFF_CONTENT && w_strb_q[1:0] == 2'b11
    |=> content_rd == $past(w_data_q[11:0]))
    else $error("content write not stored");

  chk_out_hold: assert property (
    pix_valid_out && !pix_ready_in |=> $stable(pix_data_out) && pix_valid_out)
    else $error("output pixel dropped under stall");

  cov_power_pixel: cover property (
    pop && table_enable_state_q && table_kind_q == KIND_POWER);
  cov_table_pixel: cover property (
    pop && table_enable_state_q && table_kind_q == KIND_PROG);
  cov_content_wr: cover property (do_write && aw_addr_q == OFF_CONTENT);
  cov_fifo_full: cover property (!pix_ready_out ##1 pix_ready_out);

endmodule : pixel_lookup_table

`default_nettype wire

// ===== pixel_lookup_table_test.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module pixel_lookup_table_test
  import lut_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  typedef struct packed {
    logic        pix;
    logic [7:0]  addr;
    logic [31:0] wd;
    logic [31:0] ex;
  } row_t;

  logic              mclk      = 1'b0;
  logic              rstn      = 1'b0;
  logic [ADDR_W-1:0] awaddr    = 8'h00;
  logic              awvalid   = 1'b0;
  logic [DATA_W-1:0] wdata     = 32'h0;
  logic              wvalid    = 1'b0;
  logic              bready    = 1'b0;
  logic [ADDR_W-1:0] araddr    = 8'h00;
  logic              arvalid   = 1'b0;
  logic              rready    = 1'b0;
  logic [PIX_W-1:0]  pix_data  = 12'h000;
  logic              pix_valid = 1'b0;
  logic              pix_rdy   = 1'b1;
  logic              awready_out, wready_out, bvalid_out, arready_out;
  logic              rvalid_out, pix_ready_out, pix_valid_out;
  logic [1:0]        bresp_out, rresp_out;
  logic [DATA_W-1:0] rdata_out;
  logic [PIX_W-1:0]  pix_data_out;
  int                bad_count = 0;
  int                cmp_count = 0;
  int                cycles    = 0;

  // Register rows write then read back; pixel rows map one pixel
  localparam int NROWS = 19;
  row_t rows [NROWS] = '{
    '{1'b0, OFF_POS,     32'h005, 32'h005},
    '{1'b0, OFF_CONTENT, 32'habc, 32'habc},
    '{1'b0, OFF_POS,     32'hfff, 32'hfff},
    '{1'b0, OFF_CONTENT, 32'h7e1, 32'h7e1},
    '{1'b0, OFF_CHOICE,  32'h003, 32'h000},
    '{1'b0, OFF_WIDTH,   32'h007, 32'h000},
    '{1'b0, OFF_FACTOR,  32'h280, 32'h280},
    '{1'b0, OFF_FACTOR,  32'h100, 32'h100},
    '{1'b1, 8'h00,       32'h005, 32'h005},
    '{1'b0, OFF_CTRL,    32'h001, 32'h001},
    '{1'b1, 8'h00,       32'h005, 32'habc},
    '{1'b1, 8'h00,       32'hfff, 32'h7e1},
    '{1'b0, OFF_CTRL,    32'h003, 32'h003},
    '{1'b1, 8'h00,       32'h000, 32'h000},
    '{1'b1, 8'h00,       32'hfff, 32'hff8},
    '{1'b0, OFF_FACTOR,  32'h000, 32'h000},
    '{1'b1, 8'h00,       32'h001, 32'hfff},
    '{1'b0, OFF_CTRL,    32'h000, 32'h000},
    '{1'b1, 8'h00,       32'h123, 32'h123}
  };
  logic [7:0]  rst_a [5] = '{OFF_CTRL, OFF_FACTOR, OFF_CHOICE, OFF_WIDTH,
                             OFF_POS};
  logic [31:0] rst_e [5] = '{32'h0, {20'h0, FACTOR_RST}, 32'h0,
                             {28'h0, WIDTH_TWELVE}, {20'h0, POS_RST}};

  always #4 mclk = ~mclk;

  pixel_lookup_table dut (
    .mclk_in       (mclk),
    .rstn_in       (rstn),
    .awaddr_in     (awaddr),
    .awvalid_in    (awvalid),
    .awready_out   (awready_out),
    .wdata_in      (wdata),
    .wstrb_in      (4'hf),
    .wvalid_in     (wvalid),
    .wready_out    (wready_out),
    .bresp_out     (bresp_out),
    .bvalid_out    (bvalid_out),
    .bready_in     (bready),
    .araddr_in     (araddr),
    .arvalid_in    (arvalid),
    .arready_out   (arready_out),
    .rdata_out     (rdata_out),
    .rresp_out     (rresp_out),
    .rvalid_out    (rvalid_out),
    .rready_in     (rready),
    .pix_data_in   (pix_data),
    .pix_valid_in  (pix_valid),
    .pix_ready_out (pix_ready_out),
    .pix_data_out  (pix_data_out),
    .pix_valid_out (pix_valid_out),
    .pix_ready_in  (pix_rdy)
  );

  // ==========================================================
  // Bus and stream tasks
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] rs);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge mclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (awvalid && awready_out) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wvalid && wready_out) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(posedge mclk); while (!bvalid_out);
    rs = bresp_out;
    bready <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] rs);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge mclk); while (!arready_out);
    arvalid <= 1'b0;
    while (!rvalid_out) @(posedge mclk);
    d  = rdata_out;
    rs = rresp_out;
    rready <= 1'b0;
  endtask : bus_rd

  task automatic pix_one(input logic [11:0] p, output logic [11:0] q);
    @(posedge mclk);
    pix_data  <= p;
    pix_valid <= 1'b1;
    do @(posedge mclk); while (!pix_ready_out);
    pix_valid <= 1'b0;
    do @(posedge mclk); while (!pix_valid_out);
    q = pix_data_out;
  endtask : pix_one

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // Guard against a hung handshake
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] rd;
    logic [1:0]  rs;
    logic [11:0] px;
    int          n;
    int          idle;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < NROWS; i++) begin
      if (rows[i].pix) begin
        pix_one(rows[i].wd[11:0], px);
        `CHK(px, rows[i].ex[11:0])
      end else begin
        bus_wr(rows[i].addr, rows[i].wd, rs);
        `CHK(rs, RESP_OKAY)
        bus_rd(rows[i].addr, rd, rs);
        `CHK(rd, rows[i].ex)
      end
    end
    $display("test rows done");
    // Unmapped place: refused on both paths
    bus_wr(8'h40, 32'h1, rs);
    `CHK(rs, RESP_SLVERR)
    bus_rd(8'h40, rd, rs);
    `CHK(rs, RESP_SLVERR)
    `CHK(rd, 32'h0)
    $display("test unmapped done");
    // Second reset in mid-run restores settings
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    for (int j = 0; j < 5; j++) begin
      bus_rd(rst_a[j], rd, rs);
      `CHK(rd, rst_e[j])
    end
    $display("test reset done");
    // Fill with output stalled until refused, then drain in order
    @(posedge mclk);
    pix_rdy   <= 1'b0;
    pix_data  <= 12'h100;
    pix_valid <= 1'b1;
    n = 0;
    idle = 0;
    while (idle < 6) begin
      @(posedge mclk);
      if (pix_ready_out) begin
        n++;
        pix_data <= 12'h100 + n[11:0];
        idle = 0;
      end else begin
        idle++;
      end
    end
    pix_valid <= 1'b0;
    `CHK(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 2, 1'b1)
    bus_rd(OFF_STATUS, rd, rs);
    `CHK(rd[2:0], 3'b011)
    pix_rdy <= 1'b1;
    for (int k = 0; k < n; k++) begin
      do @(posedge mclk); while (!pix_valid_out);
      `CHK(pix_data_out, 12'h100 + k[11:0])
    end
    bus_rd(OFF_STATUS, rd, rs);
    `CHK(rd[2:0], 3'b100)
    $display("test fifo done");
    wrap_up();
  end

endmodule : pixel_lookup_table_test

`default_nettype wire
